/* dbw_pkg.sv */
// constants shared by the loop bandwidth configuration registers
package dbw_pkg;

  // bus geometry
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 12;
  localparam int          ADDR_LSB       = 2;
  localparam int          IDX_W          = ADDR_W - ADDR_LSB;
  localparam int          TRANS_BIT      = 1;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] SEC_BW_IDX    = 10'h066;
  localparam logic [IDX_W-1:0] LOCKED_BW_IDX = 10'h067;
  localparam logic [IDX_W-1:0] BW_MODE_IDX   = 10'h03b;

  // field layouts
  localparam int          SEC_W          = 2;
  localparam int          LOCKED_W       = 5;
  localparam int          MODE_BIT_POS   = 7;

  // reset values
  localparam logic [SEC_W-1:0]    SEC_BW_RST    = 2'h0;
  localparam logic [LOCKED_W-1:0] LOCKED_BW_RST = 5'h0b;
  localparam logic                MODE_RST      = 1'b0;

  // secondary loop codes and bandwidths in hertz
  localparam logic [SEC_W-1:0] SEC_CODE_18HZ = 2'h0;
  localparam logic [SEC_W-1:0] SEC_CODE_35HZ = 2'h1;
  localparam logic [SEC_W-1:0] SEC_CODE_70HZ = 2'h2;
  localparam logic [SEC_W-1:0] SEC_CODE_UNUSED = 2'h3;
  localparam int               HZ_W          = 8;
  localparam logic [HZ_W-1:0]  SEC_HZ_18     = 8'h12;
  localparam logic [HZ_W-1:0]  SEC_HZ_35     = 8'h23;
  localparam logic [HZ_W-1:0]  SEC_HZ_70     = 8'h46;

  // main loop locked codes: millihertz range ends at code 6, defined codes end at 17
  localparam logic [LOCKED_W-1:0] LOCKED_LAST_MHZ_CODE = 5'h06;
  localparam logic [LOCKED_W-1:0] LOCKED_TOP_CODE      = 5'h11;
  localparam int                  MHZ_W                = 8;
  localparam int                  MHZ_CODES            = 7;
  // millihertz values, code 0 in the low slot
  localparam logic [MHZ_CODES-1:0][MHZ_W-1:0] LOCKED_MHZ_TBL =
    {8'h3c, 8'h1e, 8'h0f, 8'h08, 8'h04, 8'h02, 8'h01};

  // zero constants
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : dbw_pkg

/* dbw_regs.sv */
// AHB-Lite register bank for the secondary and main loop bandwidth settings
// What this block does
// - two-bit secondary code picks 18, 35 or 70 Hz; code 3 unused
// - five-bit locked code 0 to 6 picks 1 to 60 millihertz
// - locked codes 7 to 17 lie in hertz range, top defined code 17
// - mode bit 7 applies locked bandwidth always or only once phase locked
`timescale 1ns/1ps
`default_nettype none

module dbw_regs
  import dbw_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [dbw_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [dbw_pkg::DATA_W-1:0] hwdata,
  input  wire logic                      hready,
  output logic      [dbw_pkg::DATA_W-1:0] hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // loop status from the main pll
  input  wire logic                      phase_locked,
  // secondary pll settings
  output logic      [dbw_pkg::SEC_W-1:0]  secondary_loop_bw_sel,
  output logic      [dbw_pkg::HZ_W-1:0]   secondary_bw_hz,
  output logic                           secondary_code_valid,
  // main pll settings
  output logic      [dbw_pkg::LOCKED_W-1:0] main_loop_locked_bw_sel,
  output logic      [dbw_pkg::MHZ_W-1:0]  main_locked_bw_mhz,
  output logic                           main_locked_hz_range,
  output logic                           main_locked_code_valid,
  output logic                           main_locked_bw_apply
);
  import dbw_pkg::*;

  // bus data phase state
  logic                  wr_pend_ff;
  logic                  nxt_wr_pend;
  logic [IDX_W-1:0]      wr_idx_ff;
  logic [IDX_W-1:0]      nxt_wr_idx;
  logic [DATA_W-1:0]     hrdata_ff;
  logic [DATA_W-1:0]     nxt_hrdata;

  // configuration state
  logic [SEC_W-1:0]      sec_bw_ff;
  logic [SEC_W-1:0]      nxt_sec_bw;
  logic [LOCKED_W-1:0]   locked_bw_ff;
  logic [LOCKED_W-1:0]   nxt_locked_bw;
  logic                  mode_always_ff;
  logic                  nxt_mode_always;

  // decoded outputs
  logic [HZ_W-1:0]       sec_hz_ff;
  logic [HZ_W-1:0]       nxt_sec_hz;
  logic                  sec_valid_ff;
  logic                  nxt_sec_valid;
  logic [MHZ_W-1:0]      locked_mhz_ff;
  logic [MHZ_W-1:0]      nxt_locked_mhz;
  logic                  locked_hz_ff;
  logic                  nxt_locked_hz;
  logic                  locked_valid_ff;
  logic                  nxt_locked_valid;
  logic                  apply_ff;
  logic                  nxt_apply;

  logic                  addr_phase;
  logic [IDX_W-1:0]      addr_idx;

  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // hrdata is zero outside a read data phase, so a stale word never lingers
  assign hrdata    = hrdata_ff;

  // hsize is not decoded: only aligned whole-word transfers are expected
  assign addr_phase = hsel && hready && htrans[TRANS_BIT];
  assign addr_idx   = haddr[ADDR_W-1:ADDR_LSB];

  // bus sequencing
  always_comb
  begin
    nxt_wr_pend = addr_phase && hwrite;
    nxt_wr_idx  = addr_phase ? addr_idx : wr_idx_ff;
    nxt_hrdata  = DATA_ZERO;
    // read mux uses next values so a read right after a write sees the new data
    if (addr_phase && !hwrite)
    begin
      unique case (addr_idx)
        SEC_BW_IDX:    nxt_hrdata = {{(DATA_W-SEC_W){1'b0}}, nxt_sec_bw};
        LOCKED_BW_IDX: nxt_hrdata = {{(DATA_W-LOCKED_W){1'b0}}, nxt_locked_bw};
        // the mode word holds only its one bit; the rest reads zero
        BW_MODE_IDX:   nxt_hrdata = DATA_W'(nxt_mode_always) << MODE_BIT_POS;
        default:       nxt_hrdata = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= '0;
      hrdata_ff  <= DATA_ZERO;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff  <= nxt_wr_idx;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  // register writes take only the defined field bits
  always_comb
  begin
    nxt_sec_bw      = sec_bw_ff;
    nxt_locked_bw   = locked_bw_ff;
    nxt_mode_always = mode_always_ff;
    // unused codes are kept as written so software reads back its own value
    if (wr_pend_ff)
    begin
      unique case (wr_idx_ff)
        SEC_BW_IDX:    nxt_sec_bw      = hwdata[SEC_W-1:0];
        LOCKED_BW_IDX: nxt_locked_bw   = hwdata[LOCKED_W-1:0];
        BW_MODE_IDX:   nxt_mode_always = hwdata[MODE_BIT_POS];
        default:       nxt_sec_bw      = sec_bw_ff;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sec_bw_ff      <= SEC_BW_RST;
      locked_bw_ff   <= LOCKED_BW_RST;
      mode_always_ff <= MODE_RST;
    end
    else
    begin
      sec_bw_ff      <= nxt_sec_bw;
      locked_bw_ff   <= nxt_locked_bw;
      mode_always_ff <= nxt_mode_always;
    end
  end

  // bandwidth decode, registered so the loop filters see glitch-free values
  always_comb
  begin
    nxt_sec_valid = 1'b1;
    unique case (sec_bw_ff)
      SEC_CODE_18HZ: nxt_sec_hz = SEC_HZ_18;
      SEC_CODE_35HZ: nxt_sec_hz = SEC_HZ_35;
      SEC_CODE_70HZ: nxt_sec_hz = SEC_HZ_70;
      default:
      begin
        // unused code: report zero rather than guess a loop setting
        nxt_sec_hz    = '0;
        nxt_sec_valid = 1'b0;
      end
    endcase
  end

  // millihertz codes index a table; hertz codes carry no number here
  function automatic logic [MHZ_W-1:0] dbw_mhz_of(input logic [LOCKED_W-1:0] code);
    logic [MHZ_W-1:0] val;
    val = '0;
    if (code <= LOCKED_LAST_MHZ_CODE)
    begin
      val = LOCKED_MHZ_TBL[code];
    end
    return val;
  endfunction : dbw_mhz_of

  always_comb
  begin
    nxt_locked_mhz   = dbw_mhz_of(locked_bw_ff);
    nxt_locked_hz    = (locked_bw_ff > LOCKED_LAST_MHZ_CODE)
                       && (locked_bw_ff <= LOCKED_TOP_CODE);
    nxt_locked_valid = (locked_bw_ff <= LOCKED_TOP_CODE);
    // lock is a level; a lock pulse shorter than one clock is missed
    nxt_apply        = mode_always_ff || phase_locked;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sec_hz_ff       <= SEC_HZ_18;
      sec_valid_ff    <= 1'b1;
      locked_mhz_ff   <= '0;
      locked_hz_ff    <= 1'b1;
      locked_valid_ff <= 1'b1;
      apply_ff        <= 1'b0;
    end
    else
    begin
      sec_hz_ff       <= nxt_sec_hz;
      sec_valid_ff    <= nxt_sec_valid;
      locked_mhz_ff   <= nxt_locked_mhz;
      locked_hz_ff    <= nxt_locked_hz;
      locked_valid_ff <= nxt_locked_valid;
      apply_ff        <= nxt_apply;
    end
  end

  assign secondary_loop_bw_sel   = sec_bw_ff;
  assign secondary_bw_hz         = sec_hz_ff;
  assign secondary_code_valid    = sec_valid_ff;
  assign main_loop_locked_bw_sel = locked_bw_ff;
  assign main_locked_bw_mhz      = locked_mhz_ff;
  assign main_locked_hz_range    = locked_hz_ff;
  assign main_locked_code_valid  = locked_valid_ff;
  assign main_locked_bw_apply    = apply_ff;

  // checks; bus checks look one edge past the address or data phase
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sec_write_a: assert property (wr_pend_ff && wr_idx_ff == SEC_BW_IDX |=>
    secondary_loop_bw_sel == $past(hwdata[SEC_W-1:0]))
    else $error("secondary code not stored from write");

  sec_hz_map_a: assert property (##1 (secondary_bw_hz ==
    ($past(sec_bw_ff) == SEC_CODE_18HZ ? SEC_HZ_18 :
     $past(sec_bw_ff) == SEC_CODE_35HZ ? SEC_HZ_35 :
     $past(sec_bw_ff) == SEC_CODE_70HZ ? SEC_HZ_70 : '0)))
    else $error("secondary bandwidth decode wrong");

  locked_write_a: assert property (wr_pend_ff && wr_idx_ff == LOCKED_BW_IDX |=>
    main_loop_locked_bw_sel == $past(hwdata[LOCKED_W-1:0]))
    else $error("locked code not stored from write");

  locked_mhz_a: assert property (locked_bw_ff == LOCKED_LAST_MHZ_CODE
    && $stable(locked_bw_ff) |=>
    main_locked_bw_mhz == LOCKED_MHZ_TBL[MHZ_CODES-1] && !main_locked_hz_range)
    else $error("sixty millihertz code decoded wrong");

  hz_range_a: assert property (locked_bw_ff == LOCKED_TOP_CODE |=>
    main_locked_hz_range && main_locked_code_valid)
    else $error("top code not in hertz range");

  apply_mode_a: assert property (##1 main_locked_bw_apply ==
    ($past(mode_always_ff) || $past(phase_locked)))
    else $error("locked bandwidth apply wrong");

  unused_zero_a: assert property (addr_phase && !hwrite && addr_idx == SEC_BW_IDX |=>
    hrdata[DATA_W-1:SEC_W] == '0)
    else $error("unused secondary bits not zero");

  bad_code_a: assert property (sec_bw_ff == SEC_CODE_UNUSED |=> !secondary_code_valid)
    else $error("unused secondary code not flagged");

  sec_valid_a: assert property (sec_bw_ff != SEC_CODE_UNUSED |=> secondary_code_valid)
    else $error("defined secondary code flagged unused");

  locked_hz_a: assert property (locked_bw_ff > LOCKED_LAST_MHZ_CODE
    && locked_bw_ff <= LOCKED_TOP_CODE |=> main_locked_hz_range && main_locked_code_valid
    && main_locked_bw_mhz == '0)
    else $error("hertz range code decoded wrong");

  locked_bad_a: assert property (locked_bw_ff > LOCKED_TOP_CODE |=>
    !main_locked_code_valid && !main_locked_hz_range)
    else $error("undefined locked code not flagged");

  mode_write_a: assert property (wr_pend_ff && wr_idx_ff == BW_MODE_IDX |=>
    mode_always_ff == $past(hwdata[MODE_BIT_POS]))
    else $error("mode bit not stored from write");

  locked_unused_a: assert property (addr_phase && !hwrite
    && addr_idx == LOCKED_BW_IDX |=> hrdata[DATA_W-1:LOCKED_W] == '0)
    else $error("unused locked bits not zero");

  unmapped_keep_a: assert property (wr_pend_ff && wr_idx_ff != SEC_BW_IDX
    && wr_idx_ff != LOCKED_BW_IDX && wr_idx_ff != BW_MODE_IDX |=>
    $stable(sec_bw_ff) && $stable(locked_bw_ff) && $stable(mode_always_ff))
    else $error("unmapped write changed a setting");

  unmapped_read_a: assert property (addr_phase && !hwrite && addr_idx != SEC_BW_IDX
    && addr_idx != LOCKED_BW_IDX && addr_idx != BW_MODE_IDX |=> hrdata == '0)
    else $error("unmapped read not zero");

  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");

  // scenarios worth seeing at least once; decode lags the stored code by one edge
  sec_wr_c: cover property (wr_pend_ff && wr_idx_ff == SEC_BW_IDX ##2 secondary_bw_hz == SEC_HZ_70);
  hz_top_c: cover property (locked_bw_ff == LOCKED_TOP_CODE ##1 main_locked_hz_range);
  bad_locked_c: cover property (locked_bw_ff > LOCKED_TOP_CODE ##1 !main_locked_code_valid);
  lock_apply_c: cover property (!mode_always_ff && $rose(phase_locked) ##1 main_locked_bw_apply);
  rd_after_wr_c: cover property (wr_pend_ff && addr_phase && !hwrite);

endmodule : dbw_regs

`default_nettype wire

/* dbw_regs_bench.sv */
// self-checking bench for the loop bandwidth configuration registers
`timescale 1ns/1ps
`default_nettype none

module dbw_regs_bench;
  import dbw_pkg::*;

  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] w; logic [9:0] ex;} dbw_row_t;

  localparam logic [ADDR_W-1:0] A_SEC = {SEC_BW_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_LCK = {LOCKED_BW_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_MOD = {BW_MODE_IDX, 2'b00};

  logic                  clk, rst_n, hsel, hwrite, phase_locked;
  logic [ADDR_W-1:0]     haddr;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [DATA_W-1:0]     hwdata, hrdata, d, m;
  logic                  hready, hreadyout, hresp;
  logic [SEC_W-1:0]      sec_sel;
  logic [HZ_W-1:0]       sec_hz;
  logic                  sec_ok, hz_rng, lck_ok, apply;
  logic [LOCKED_W-1:0]   lck_sel;
  logic [MHZ_W-1:0]      lck_mhz;
  int                    bad_count, cmp_count;

  // upper data bits are junk on purpose: only the field may stick
  dbw_row_t rows [14] = '{
    '{A_SEC, 32'hFFFF_FFFC, 10'h112}, '{A_SEC, 32'hFFFF_FFFD, 10'h123},
    '{A_SEC, 32'hFFFF_FFFE, 10'h146}, '{A_SEC, 32'hFFFF_FFFF, 10'h000},
    '{A_LCK, 32'hFFFF_FFE0, 10'h201}, '{A_LCK, 32'hFFFF_FFE1, 10'h202},
    '{A_LCK, 32'hFFFF_FFE2, 10'h204}, '{A_LCK, 32'hFFFF_FFE3, 10'h208},
    '{A_LCK, 32'hFFFF_FFE4, 10'h20F}, '{A_LCK, 32'hFFFF_FFE5, 10'h21E},
    '{A_LCK, 32'hFFFF_FFE6, 10'h23C}, '{A_LCK, 32'hFFFF_FFE7, 10'h300},
    '{A_LCK, 32'hFFFF_FFF1, 10'h300}, '{A_LCK, 32'hFFFF_FFF2, 10'h000}};

  assign hready = hreadyout;

  dbw_regs DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_locked(phase_locked),
    .secondary_loop_bw_sel(sec_sel), .secondary_bw_hz(sec_hz),
    .secondary_code_valid(sec_ok), .main_loop_locked_bw_sel(lck_sel),
    .main_locked_bw_mhz(lck_mhz), .main_locked_hz_range(hz_rng),
    .main_locked_code_valid(lck_ok), .main_locked_bw_apply(apply));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one single transfer; waits on hready, takes read data at the data phase edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask : bus

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [31:0] outv();
    return {5'h0, apply, hz_rng, lck_ok, lck_mhz, sec_ok, sec_hz, sec_sel, lck_sel};
  endfunction : outv

  localparam logic [31:0] RST_OUT = {5'h0, 3'b011, 8'h00, 1'b1, SEC_HZ_18, SEC_BW_RST,
                                     LOCKED_BW_RST};

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    phase_locked = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset outputs", outv(), RST_OUT);
    bus(1'b0, A_LCK, '0, d);
    chk("locked reset read", d, 32'h0000_000B);
    foreach (rows[i])
    begin
      m = rows[i].w & ((rows[i].a == A_SEC) ? 32'h3 : 32'h1F);
      bus(1'b1, rows[i].a, rows[i].w, d);
      bus(1'b0, rows[i].a, '0, d);
      chk("readback", d, m);
      settle();
      d = (rows[i].a == A_SEC) ? {21'h0, 2'b00, sec_ok, sec_hz} : {22'h0, lck_ok, hz_rng, lck_mhz};
      chk("decode", d, {22'h0, rows[i].ex});
      d = (rows[i].a == A_SEC) ? {27'h0, 3'b000, sec_sel} : {27'h0, lck_sel};
      chk("field out", d, m);
    end
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, A_MOD, {24'hFF_FFFF, i[1], 7'h7F}, d);
      phase_locked <= i[0];
      settle();
      chk("apply", apply, i[1] | i[0]);
      bus(1'b0, A_MOD, '0, d);
      chk("mode read", d, {24'h0, i[1], 7'h00});
    end
    // unmapped place must neither store nor disturb the secondary setting
    bus(1'b1, 12'h000, 32'hFFFF_FFFF, d);
    bus(1'b0, 12'h000, '0, d);
    chk("unmapped read", d, 32'h0);
    bus(1'b0, A_SEC, '0, d);
    chk("sec kept", d, 32'h3);
    @(posedge clk);
    rst_n <= 1'b0;
    phase_locked <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("mid reset outputs", outv(), RST_OUT);
    test_done();
  end

endmodule : dbw_regs_bench

`default_nettype wire
